//--- logic/hmac_pkg.sv
// package of the multiply-accumulate unit: map, fields, resets, carriers
// assumes a 32-bit apb slave with byte addresses in the low eight bits
package hmac_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int unsigned OPW   = 16;
	localparam int unsigned PRODW = 32;
	localparam int unsigned ACCW  = 48;
	localparam int unsigned DW    = 32;
	localparam int unsigned AW    = 8;
	localparam int unsigned IRQW  = 2;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [AW-1:0] ADDR_OPA     = 8'h00;
	localparam logic [AW-1:0] ADDR_OPB     = 8'h04;
	localparam logic [AW-1:0] ADDR_ACC_LO  = 8'h08;
	localparam logic [AW-1:0] ADDR_ACC_MID = 8'h0c;
	localparam logic [AW-1:0] ADDR_ACC_HI  = 8'h10;
	localparam logic [AW-1:0] ADDR_PROD_LO = 8'h14;
	localparam logic [AW-1:0] ADDR_PROD_HI = 8'h18;
	localparam logic [AW-1:0] ADDR_CTRL    = 8'h1c;
	localparam logic [AW-1:0] ADDR_IRQ_ST  = 8'h20;
	localparam logic [AW-1:0] ADDR_IRQ_CLR = 8'h24;
	localparam logic [AW-1:0] ADDR_IRQ_EN  = 8'h28;

	// ----------------------------------------
	// control/status fields and operations
	// ----------------------------------------
	localparam int unsigned CTL_SIGNED = 0;
	localparam int unsigned CTL_OP_LSB = 1;
	localparam int unsigned CTL_OVF    = 3;
	localparam int unsigned CTL_BUSY   = 4;
	localparam logic [1:0]  OP_MUL     = 2'h0;
	localparam logic [1:0]  OP_MAC     = 2'h1;
	localparam logic [1:0]  OP_MSU     = 2'h2;
	localparam logic [1:0]  OP_NEG     = 2'h3;
	localparam int unsigned IRQ_DONE   = 0;
	localparam int unsigned IRQ_OVF    = 1;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [OPW-1:0]  RST_OP  = 16'h0000;
	localparam logic [ACCW-1:0] RST_ACC = 48'h0000_0000_0000;
	localparam logic [1:0]      RST_OPC = 2'h0;
	localparam logic [IRQW-1:0] RST_IRQ = 2'h0;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [ACCW-1:0]  p48;
		logic [PRODW-1:0] p32;
	} hmac_prod_t;

	typedef struct packed {
		logic [OPW-1:0]   opa;
		logic [OPW-1:0]   opb;
		logic             have_a;
		logic             have_b;
		logic             sgn;
		logic [1:0]       opc;
		logic             ovf;
		logic             run_sgn;
		logic [1:0]       run_op;
		logic             s1;
		logic             s2;
		logic [ACCW-1:0]  p48;
		logic [ACCW-1:0]  acc;
		logic [PRODW-1:0] prod;
		logic [IRQW-1:0]  irq_st;
		logic [IRQW-1:0]  irq_en;
		logic             irq;
		logic [DW-1:0]    prdata;
		logic             pready;
		logic             pslverr;
	} hmac_st_t;

endpackage

//--- logic/hmac_mult.sv
// 16x16 multiplier core with ones' complement negate and sign fix-up
// purely combinational; operands come from registers of the same clock
`timescale 1ns/1ps
`default_nettype none
module hmac_mult
	import hmac_pkg::*;
(
	input  wire logic [15:0]       a,
	input  wire logic [15:0]       b,
	input  wire logic              sgn,
	input  wire logic              neg,
	output hmac_pkg::hmac_prod_t   res
);
	logic signed [16:0] a17;
	logic signed [16:0] b17;
	logic signed [16:0] na;
	logic signed [34:0] full;

	// ----------------------------------------
	// arithmetic
	// ----------------------------------------
	always_comb begin
		a17 = sgn ? {a[15], a} : {1'b0, a};
		b17 = sgn ? {b[15], b} : {1'b0, b};
		// ~a*b + b equals -(a*b); the extra b is the sign fix-up
		na = neg ? ~a17 : a17;
		full = 35'(na * b17) + (neg ? 35'(b17) : 35'sd0);
		res.p32 = full[31:0];
		res.p48 = {{13{full[34]}}, full};
	end
endmodule
`default_nettype wire

//--- logic/hmac_acc_add.sv
// accumulator adder with overflow detect for signed and unsigned forms
// purely combinational; addend is the sign-extended 48-bit product
`timescale 1ns/1ps
`default_nettype none
module hmac_acc_add
	import hmac_pkg::*;
(
	input  wire logic [47:0] acc,
	input  wire logic [47:0] addend,
	input  wire logic        sgn,
	output logic      [47:0] sum,
	output logic             ovf
);
	logic [49:0] wide;

	// ----------------------------------------
	// add and range check
	// ----------------------------------------
	always_comb begin
		wide = (sgn ? {{2{acc[47]}}, acc} : {2'b00, acc})
			+ {{2{addend[47]}}, addend};
		sum = wide[47:0];
		// unsigned leaves 0..2^48-1, signed leaves the 48-bit range
		ovf = sgn ? (wide[48] != wide[47]) : (wide[49:48] != 2'b00);
	end
endmodule
`default_nettype wire

//--- logic/hmac_top.sv
// multiply-accumulate peripheral: apb register file, two-stage datapath
// assumes one clock pclk and an apb master; pready has one wait state
//
// How it works
// - full 16x16 product, 48-bit accumulator
// - four operations, core never stalled
// - plain and negate one cycle, others two
// - accumulator as high, mid, low words
// - overflow bit in control/status register
// - load operands, then operation starts
// - product registers valid one cycle later
// - MAC/MSU accumulator valid after one wait cycle
// - product summed with zero or accumulator
// - sum read straight from accumulator words
// - negate forms invert first operand, fix sign
`timescale 1ns/1ps
`default_nettype none
module hmac_top
	import hmac_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [hmac_pkg::AW-1:0] paddr,
	input  wire logic [hmac_pkg::DW-1:0] pwdata,
	output logic      [hmac_pkg::DW-1:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic                       irq
);
	import hmac_pkg::*;

	hmac_st_t   st;
	hmac_st_t   next_st;
	hmac_prod_t mres;
	logic [ACCW-1:0] add_sum;
	logic            add_ovf;
	logic            commit;
	logic            wr;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic mapped(input logic [AW-1:0] a);
		case (a)
			ADDR_OPA, ADDR_OPB, ADDR_ACC_LO, ADDR_ACC_MID,
			ADDR_ACC_HI, ADDR_PROD_LO, ADDR_PROD_HI, ADDR_CTRL,
			ADDR_IRQ_ST, ADDR_IRQ_CLR, ADDR_IRQ_EN: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [DW-1:0] rd_mux(input logic [AW-1:0] a,
		input hmac_st_t s);
		logic [DW-1:0] v;
		v = '0;
		case (a)
			ADDR_OPA:     v[15:0] = s.opa;
			ADDR_OPB:     v[15:0] = s.opb;
			ADDR_ACC_LO:  v[15:0] = s.acc[15:0];
			ADDR_ACC_MID: v[15:0] = s.acc[31:16];
			ADDR_ACC_HI:  v[15:0] = s.acc[47:32];
			ADDR_PROD_LO: v[15:0] = s.prod[15:0];
			ADDR_PROD_HI: v[15:0] = s.prod[31:16];
			ADDR_CTRL: begin
				v[CTL_SIGNED] = s.sgn;
				v[CTL_OP_LSB +: 2] = s.opc;
				v[CTL_OVF] = s.ovf;
				v[CTL_BUSY] = s.s1 | s.s2;
			end
			ADDR_IRQ_ST:  v[IRQW-1:0] = s.irq_st;
			ADDR_IRQ_EN:  v[IRQW-1:0] = s.irq_en;
			default:      v = '0;
		endcase
		rd_mux = v;
	endfunction

	// ----------------------------------------
	// datapath pieces
	// ----------------------------------------
	hmac_mult u_mult (
		.a   (st.opa),
		.b   (st.opb),
		.sgn (st.run_sgn),
		.neg ((st.run_op == OP_MSU) || (st.run_op == OP_NEG)),
		.res (mres)
	);

	hmac_acc_add u_add (
		.acc    (st.acc),
		.addend (st.p48),
		.sgn    (st.run_sgn),
		.sum    (add_sum),
		.ovf    (add_ovf)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		commit = psel & penable & st.pready;
		wr = commit & pwrite;
		// one wait state keeps every bus output straight off a flop
		next_st.pready = psel & penable & ~st.pready;
		next_st.prdata = '0;
		next_st.pslverr = 1'b0;
		if (psel && penable && !st.pready) begin
			next_st.prdata = pwrite ? '0 : rd_mux(paddr, st);
			next_st.pslverr = ~mapped(paddr);
		end
		next_st.s1 = 1'b0;
		next_st.s2 = 1'b0;

		// software writes
		if (wr) begin
			case (paddr)
				ADDR_OPA: begin
					next_st.opa = pwdata[15:0];
					next_st.have_a = 1'b1;
				end
				ADDR_OPB: begin
					next_st.opb = pwdata[15:0];
					next_st.have_b = 1'b1;
				end
				ADDR_ACC_LO:  next_st.acc[15:0] = pwdata[15:0];
				ADDR_ACC_MID: next_st.acc[31:16] = pwdata[15:0];
				ADDR_ACC_HI:  next_st.acc[47:32] = pwdata[15:0];
				ADDR_CTRL: begin
					next_st.sgn = pwdata[CTL_SIGNED];
					next_st.opc = pwdata[CTL_OP_LSB +: 2];
					next_st.ovf = pwdata[CTL_OVF];
				end
				ADDR_IRQ_CLR:
					next_st.irq_st = st.irq_st & ~pwdata[IRQW-1:0];
				ADDR_IRQ_EN:  next_st.irq_en = pwdata[IRQW-1:0];
				default: begin
				end
			endcase
		end

		// start once both operands are in; the mode is latched here
		if (next_st.have_a && next_st.have_b) begin
			next_st.have_a = 1'b0;
			next_st.have_b = 1'b0;
			next_st.s1 = 1'b1;
			next_st.run_sgn = next_st.sgn;
			next_st.run_op = next_st.opc;
		end

		// stage one: product; plain forms finish here
		if (st.s1) begin
			next_st.prod = mres.p32;
			if (st.run_op == OP_MUL || st.run_op == OP_NEG) begin
				next_st.acc = mres.p48;
				next_st.irq_st[IRQ_DONE] = 1'b1;
			end else begin
				next_st.p48 = mres.p48;
				next_st.s2 = 1'b1;
			end
		end

		// stage two: accumulate; hardware wins over a same-cycle write
		if (st.s2) begin
			next_st.acc = add_sum;
			next_st.irq_st[IRQ_DONE] = 1'b1;
			if (add_ovf) begin
				next_st.ovf = 1'b1;
				next_st.irq_st[IRQ_OVF] = 1'b1;
			end
		end

		next_st.irq = |(next_st.irq_st & next_st.irq_en);
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{opa: RST_OP, opb: RST_OP, have_a: 1'b0,
				have_b: 1'b0, sgn: 1'b0, opc: RST_OPC, ovf: 1'b0,
				run_sgn: 1'b0, run_op: RST_OPC, s1: 1'b0, s2: 1'b0,
				p48: RST_ACC, acc: RST_ACC, prod: 32'h0000_0000,
				irq_st: RST_IRQ, irq_en: RST_IRQ, irq: 1'b0,
				prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign prdata  = st.prdata;
	assign pready  = st.pready;
	assign pslverr = st.pslverr;
	assign irq     = st.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic signed [47:0] chk_neg;
	logic signed [47:0] chk_smul;
	logic        [47:0] chk_uneg;
	always_comb begin
		chk_neg = -(48'($signed(st.opa)) * 48'($signed(st.opb)));
		chk_smul = 48'($signed(st.opa)) * 48'($signed(st.opb));
		chk_uneg = -(48'(st.opa) * 48'(st.opb));
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_prod_one_cycle;
		st.s1 |=> st.prod == $past(mres.p32);
	endproperty
	a_prod_one_cycle: assert property (p_prod_one_cycle)
		else $error("product not registered one cycle after start");

	property p_mac_two_cycles;
		st.s1 && (st.run_op == OP_MAC || st.run_op == OP_MSU)
			|=> st.s2 ##1 !st.s2;
	endproperty
	a_mac_two_cycles: assert property (p_mac_two_cycles)
		else $error("accumulate form did not take two cycles");

	property p_plain_to_acc;
		st.s1 && (st.run_op == OP_MUL || st.run_op == OP_NEG)
			|=> !st.s2 && st.acc == $past(mres.p48);
	endproperty
	a_plain_to_acc: assert property (p_plain_to_acc)
		else $error("plain product not summed with zero");

	property p_neg_value;
		st.s1 && st.run_sgn && st.run_op == OP_NEG
			|=> $signed(st.acc) == $past(chk_neg);
	endproperty
	a_neg_value: assert property (p_neg_value)
		else $error("signed negate result wrong");

	property p_ovf_set;
		st.s2 && add_ovf |=> st.ovf && st.irq_st[IRQ_OVF];
	endproperty
	a_ovf_set: assert property (p_ovf_set)
		else $error("overflow not flagged");

	property p_ovf_hold;
		st.ovf && !(wr && paddr == ADDR_CTRL) |=> st.ovf;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold)
		else $error("overflow bit dropped without a write");

	property p_start;
		wr && (paddr == ADDR_OPB) && st.have_a
			|=> st.s1 && !st.have_a && !st.have_b ##1 !st.s1;
	endproperty
	a_start: assert property (p_start)
		else $error("operation did not start on operand load");

	property p_sum;
		st.s2 |=> st.acc == $past(add_sum) && st.irq_st[IRQ_DONE];
	endproperty
	a_sum: assert property (p_sum)
		else $error("accumulator does not hold the sum");

	property p_read_hi;
		psel && penable && !st.pready && !pwrite
			&& paddr == ADDR_ACC_HI
			|=> st.pready && st.prdata[15:0] == $past(st.acc[47:32]);
	endproperty
	a_read_hi: assert property (p_read_hi)
		else $error("high accumulator word misread");

	property p_no_stall;
		psel && penable |-> ##[0:1] st.pready;
	endproperty
	a_no_stall: assert property (p_no_stall)
		else $error("bus answer later than one wait state");

	property p_wait_cycle;
		st.s1 && (st.run_op == OP_MAC || st.run_op == OP_MSU)
			|=> ##1 !(st.s1 || st.s2) && st.irq_st[IRQ_DONE];
	endproperty
	a_wait_cycle: assert property (p_wait_cycle)
		else $error("accumulator not done after wait cycle");

	property p_umul_value;
		st.s1 && !st.run_sgn && st.run_op == OP_MUL
			|=> st.prod == $past(32'(st.opa) * 32'(st.opb));
	endproperty
	a_umul_value: assert property (p_umul_value)
		else $error("unsigned product wrong");

	property p_smul_value;
		st.s1 && st.run_sgn && st.run_op == OP_MUL
			|=> $signed(st.acc) == $past(chk_smul);
	endproperty
	a_smul_value: assert property (p_smul_value)
		else $error("signed product wrong");

	property p_msu_addend;
		st.s1 && st.run_op == OP_MSU
			|=> st.p48 == $past(st.run_sgn ? chk_neg : chk_uneg);
	endproperty
	a_msu_addend: assert property (p_msu_addend)
		else $error("subtract addend not the negated product");

	property p_prod_hold;
		!st.s1 |=> st.prod == $past(st.prod);
	endproperty
	a_prod_hold: assert property (p_prod_hold)
		else $error("product registers changed without an operation");

	property p_acc_hold;
		!st.s1 && !st.s2 && !wr |=> st.acc == $past(st.acc);
	endproperty
	a_acc_hold: assert property (p_acc_hold)
		else $error("accumulator changed without write or operation");

	property p_mode_latch;
		wr && paddr == ADDR_OPB && st.have_a
			|=> st.run_op == $past(st.opc)
			&& st.run_sgn == $past(st.sgn);
	endproperty
	a_mode_latch: assert property (p_mode_latch)
		else $error("operation mode not latched at start");

	property p_unmapped;
		psel && penable && !st.pready && !mapped(paddr)
			|=> st.pslverr && st.pready && st.prdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");

	property p_irq_level;
		st.irq == |(st.irq_st & st.irq_en);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt line disagrees with enabled status");

endmodule
`default_nettype wire

//--- tb/hmac_core_model.sv
// core-side model: apb master issuing one transfer per call
// assumes pready comes back within a bounded wait; ok reports it
`timescale 1ns/1ps
`default_nettype none
module hmac_core_model
	import hmac_pkg::*;
(
	input  wire logic                    pclk,
	output logic                         psel,
	output logic                         penable,
	output logic                         pwrite,
	output logic     [hmac_pkg::AW-1:0]  paddr,
	output logic     [hmac_pkg::DW-1:0]  pwdata,
	input  wire logic [hmac_pkg::DW-1:0] prdata,
	input  wire logic                    pready,
	input  wire logic                    pslverr
);
	// ----------------------------------------
	// idle bus
	// ----------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// ----------------------------------------
	// transfer; callers load first then second operand
	// ----------------------------------------
	task automatic xfer(input logic wr, input logic [AW-1:0] a,
		input logic [DW-1:0] wd, output logic [DW-1:0] rd,
		output logic err, output logic ok);
		int n;
		ok = 1'b0;
		rd = 32'h0;
		err = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// reads issued later than two cycles after the load
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				ok = 1'b1;
				rd = prdata;
				err = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// released data lines show a changed pattern, not stale data
		pwdata <= ~wd;
	endtask
endmodule
`default_nettype wire

//--- tb/hmac_top_tb.sv
// self-checking bench of the multiply-accumulate peripheral
// assumes hmac_core_model as apb master; expectations from a table
`timescale 1ns/1ps
`default_nettype none
module hmac_top_tb;
	import hmac_pkg::*;
	typedef struct packed {
		logic            wctl;
		logic [DW-1:0]   ctl;
		logic [ACCW-1:0] pre;
		logic [15:0]     a;
		logic [15:0]     b;
		logic [ACCW-1:0] acc;
		logic [PRODW-1:0] prod;
		logic            ovf;
	} hmac_vec_t;
	localparam hmac_vec_t VEC [10] = '{
	'{1'b1, 32'h0, 48'h1234_5678_9abc, 16'hffff, 16'hffff,
		48'h0000_fffe_0001, 32'hfffe_0001, 1'b0},
	'{1'b1, 32'h1, 48'h0, 16'hffff, 16'h0002,
		48'hffff_ffff_fffe, 32'hffff_fffe, 1'b0},
	'{1'b1, 32'h7, 48'h0, 16'h0003, 16'h0004,
		48'hffff_ffff_fff4, 32'hffff_fff4, 1'b0},
	'{1'b1, 32'h6, 48'h0, 16'h0002, 16'h0003,
		48'hffff_ffff_fffa, 32'hffff_fffa, 1'b0},
	'{1'b1, 32'h2, 48'hffff_ffff_ffff, 16'h0001, 16'h0001,
		48'h0, 32'h1, 1'b1},
	'{1'b0, 32'h2, 48'h10, 16'h0002, 16'h0003,
		48'h16, 32'h6, 1'b1},
	'{1'b1, 32'h4, 48'h16, 16'h0001, 16'h0017,
		48'hffff_ffff_ffff, 32'hffff_ffe9, 1'b1},
	'{1'b1, 32'h3, 48'h7fff_ffff_ffff, 16'h0001, 16'h0001,
		48'h8000_0000_0000, 32'h1, 1'b1},
	'{1'b1, 32'h5, 48'h0, 16'hffff, 16'h0002,
		48'h2, 32'h2, 1'b0},
	'{1'b1, 32'h2, 48'h0000_ffff_ffff, 16'hffff, 16'hffff,
		48'h0001_fffe_0000, 32'hfffe_0001, 1'b0}};

	logic          pclk, presetn, psel, penable, pwrite;
	logic          pready, pslverr, irq;
	logic [AW-1:0] paddr;
	logic [DW-1:0] pwdata, prdata;
	int            n_errors = 0;
	int            num_checks = 0;

	hmac_top u_hmac_top(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));
	hmac_core_model u_hmac_core_model(.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [DW-1:0] seen,
		input logic [DW-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [AW-1:0] a,
		input logic [DW-1:0] wd, output logic [DW-1:0] rd,
		output logic err);
		logic ok;
		u_hmac_core_model.xfer(w, a, wd, rd, err, ok);
		if (ok !== 1'b1) begin
			n_errors++;
			$display("MISMATCH pready exp 1 seen timeout");
			give_verdict();
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		logic [DW-1:0] r;
		logic e;
		bus(1'b1, a, d, r, e);
	endtask
	task automatic rdc(input string what, input logic [AW-1:0] a,
		input logic [DW-1:0] exp);
		logic [DW-1:0] r;
		logic e;
		bus(1'b0, a, 32'h0, r, e);
		check(what, r, exp);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int i;
		logic [DW-1:0] r;
		logic e;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 11; i++)
			rdc("reset value", 8'(i * 4), 32'h0);
		$display("test reset done");
		wr(ADDR_IRQ_EN, 32'h3);
		for (i = 0; i < 10; i++) begin
			if (VEC[i].wctl)
				wr(ADDR_CTRL, VEC[i].ctl);
			wr(ADDR_ACC_LO, {16'h0, VEC[i].pre[15:0]});
			wr(ADDR_ACC_MID, {16'h0, VEC[i].pre[31:16]});
			wr(ADDR_ACC_HI, {16'h0, VEC[i].pre[47:32]});
			wr(ADDR_OPA, {16'h0, VEC[i].a});
			wr(ADDR_OPB, {16'h0, VEC[i].b});
			rdc("acc_lo", ADDR_ACC_LO, {16'h0, VEC[i].acc[15:0]});
			rdc("acc_mid", ADDR_ACC_MID, {16'h0, VEC[i].acc[31:16]});
			rdc("acc_hi", ADDR_ACC_HI, {16'h0, VEC[i].acc[47:32]});
			rdc("prod_lo", ADDR_PROD_LO, {16'h0, VEC[i].prod[15:0]});
			rdc("prod_hi", ADDR_PROD_HI, {16'h0, VEC[i].prod[31:16]});
			rdc("ctrl", ADDR_CTRL, VEC[i].ctl | {28'h0, VEC[i].ovf, 3'h0});
			rdc("irq_st", ADDR_IRQ_ST,
				{30'h0, VEC[i].ovf & VEC[i].wctl, 1'b1});
			check("irq", {31'h0, irq}, 32'h1);
			wr(ADDR_IRQ_CLR, 32'h3);
			rdc("irq_st clr", ADDR_IRQ_ST, 32'h0);
			check("irq clr", {31'h0, irq}, 32'h0);
			$display("test op %0d done", i);
		end
		// unmapped, read-only and write-only places
		bus(1'b0, 8'h2c, 32'h0, r, e);
		check("slverr", {31'h0, e}, 32'h1);
		check("unmapped data", r, 32'h0);
		wr(ADDR_PROD_LO, 32'h5a5a);
		rdc("prod_lo ro", ADDR_PROD_LO, 32'h0001);
		rdc("irq_clr wo", ADDR_IRQ_CLR, 32'h0);
		$display("test bus done");
		// masked event stays in status only
		wr(ADDR_IRQ_EN, 32'h0);
		wr(ADDR_OPA, 32'h1);
		wr(ADDR_OPB, 32'h1);
		rdc("irq_st masked", ADDR_IRQ_ST, 32'h1);
		check("irq masked", {31'h0, irq}, 32'h0);
		$display("test mask done");
		give_verdict();
	end
endmodule
`default_nettype wire
